// >>> pkg/brl_pkg.sv
// Purpose: shared constants of the broadcast rate limiter
// Assumes: 200 MHz system clock, AXI4-Lite register access
// Notes: per-port registers sit in 32-byte banks from PORT_BASE
package brl_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_PORTS = 24;
  localparam int PORT_W = 5;
  localparam int CNT_W = 24;
  localparam int TOT_W = 32;
  localparam int ELAP_W = 32;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 12;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_DROPS = 12'h004;
  localparam logic [ADDR_W-1:0] PORT_BASE = 12'h100;
  localparam int PORT_SHIFT = 5;
  localparam logic [2:0] FLD_LIMIT = 3'h0;
  localparam logic [2:0] FLD_CLR = 3'h1;
  localparam logic [2:0] FLD_TOTAL = 3'h2;
  localparam logic [2:0] FLD_PEAK = 3'h3;
  localparam logic [2:0] FLD_ELAP = 3'h4;
  localparam int CTRL_SAVE_BIT = 0;
  localparam int CTRL_NOSUP_BIT = 1;
  // ==========================================================
  // Reset values and answers
  localparam logic [CNT_W-1:0] LIMIT_RST = 24'hffffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/brl_fifo.sv
// Purpose: small FIFO between limiter and forwarding
// Assumes: DEPTH a power of two
// Notes: in_ready falls when full, so the source stalls
`timescale 1ns/10ps
module brl_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] lvl_r, lvl_nxt;
  logic push, pop;

  assign in_ready = (lvl_r != FULL);
  assign out_valid = (lvl_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    lvl_nxt = lvl_r;
    if (push && !pop) begin
      lvl_nxt = lvl_r + 1'b1;
    end else if (pop && !push) begin
      lvl_nxt = lvl_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      lvl_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // Storage needs no reset; valid comes from the level
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

// >>> src/brl_tick.sv
// Purpose: one-second tick from the system clock
// Assumes: CYCLES of at least 2
// Notes: tick is a one-cycle pulse from a flip-flop
`timescale 1ns/10ps
module brl_tick #(
  parameter int CYCLES = 200000000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pulse
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    tick_nxt = (cnt_r == LAST);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// >>> src/brl_top.sv
// Purpose: per-port broadcast suppression with statistics
// Assumes: one frame descriptor per handshake on the rx side
// Notes: registers over AXI4-Lite; limits and clears apply on save, the no-suppression bit at once
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module brl_top
  import brl_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Received frames
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [PORT_W-1:0] rx_port,
  input wire logic rx_bcast,
  input wire logic [DATA_W-1:0] rx_data,
  // Permitted frames to forwarding
  output logic fwd_valid,
  input wire logic fwd_ready,
  output logic [PORT_W-1:0] fwd_port,
  output logic [DATA_W-1:0] fwd_data
);
  // ==========================================================
  // Address decode
  function automatic logic port_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - PORT_BASE;
    port_hit = (a >= PORT_BASE) &&
               ((rel >> PORT_SHIFT) < ADDR_W'(NUM_PORTS)) &&
               (rel[4:2] <= FLD_ELAP);
  endfunction

  function automatic logic [PORT_W-1:0] port_of(
      input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = (a - PORT_BASE) >> PORT_SHIFT;
    port_of = rel[PORT_W-1:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = m;
  endfunction

  // ==========================================================
  // State
  logic [CNT_W-1:0] lim_pend_r [NUM_PORTS];
  logic [CNT_W-1:0] lim_pend_nxt [NUM_PORTS];
  logic [CNT_W-1:0] lim_act_r [NUM_PORTS];
  logic [CNT_W-1:0] lim_act_nxt [NUM_PORTS];
  logic clr_pend_r [NUM_PORTS];
  logic clr_pend_nxt [NUM_PORTS];
  logic [CNT_W-1:0] cnt_r [NUM_PORTS];
  logic [CNT_W-1:0] cnt_nxt [NUM_PORTS];
  logic [CNT_W-1:0] peak_r [NUM_PORTS];
  logic [CNT_W-1:0] peak_nxt [NUM_PORTS];
  logic [TOT_W-1:0] tot_r [NUM_PORTS];
  logic [TOT_W-1:0] tot_nxt [NUM_PORTS];
  logic [ELAP_W-1:0] elap_r [NUM_PORTS];
  logic [ELAP_W-1:0] elap_nxt [NUM_PORTS];

  logic nosup_r, nosup_nxt;
  logic [31:0] drops_r, drops_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic aw_have_r, aw_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic tick, wr_do, save, wr_port_ok, fifo_in_ready;
  logic rx_fire, port_ok, over, pass;
  logic [PORT_W-1:0] wr_port, ar_port;
  logic [2:0] wr_fld, ar_fld;
  logic [CNT_W-1:0] cnt_sel, lim_sel;

  // ==========================================================
  // Second tick
  brl_tick #(
    .CYCLES(TICK_LEN)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ==========================================================
  // Admission decision
  assign rx_ready = fifo_in_ready;
  assign rx_fire = rx_valid & rx_ready;
  assign port_ok = (rx_port < PORT_W'(NUM_PORTS));
  // Frame on the tick edge already belongs to the new second
  assign cnt_sel = (tick || !port_ok) ? '0 : cnt_r[rx_port];
  assign lim_sel = port_ok ? lim_act_r[rx_port] : LIMIT_RST;
  assign over = rx_bcast & port_ok & (cnt_sel >= lim_sel);
  assign pass = !over | nosup_r;

  brl_fifo #(
    .WIDTH(PORT_W + DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(rx_valid & pass),
    .in_ready(fifo_in_ready),
    .in_data({rx_port, rx_data}),
    .out_valid(fwd_valid),
    .out_ready(fwd_ready),
    .out_data({fwd_port, fwd_data})
  );

  // ==========================================================
  // Register write and read decode
  assign wr_do = aw_have_r & w_have_r & !bvalid_r;
  assign wr_port_ok = port_hit(aw_addr_r);
  assign wr_port = port_of(aw_addr_r);
  assign wr_fld = aw_addr_r[4:2];
  assign save = wr_do & (aw_addr_r == REG_CTRL) &
                w_strb_r[0] & w_data_r[CTRL_SAVE_BIT];
  assign ar_port = port_of(s_axi_araddr);
  assign ar_fld = s_axi_araddr[4:2];

  // ==========================================================
  // Per-port limits and statistics
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic hit, wr_here;
    assign hit = rx_fire & rx_bcast & (rx_port == PORT_W'(p));
    assign wr_here = wr_do & wr_port_ok & (wr_port == PORT_W'(p));

    always_comb begin
      lim_pend_nxt[p] = lim_pend_r[p];
      clr_pend_nxt[p] = clr_pend_r[p];
      lim_act_nxt[p] = lim_act_r[p];
      tot_nxt[p] = tot_r[p];
      peak_nxt[p] = peak_r[p];
      elap_nxt[p] = elap_r[p];
      if (wr_here && wr_fld == FLD_LIMIT) begin
        // Multiples of ten are software's job; stored as written
        lim_pend_nxt[p] = CNT_W'(merge(32'(lim_pend_r[p]),
            w_data_r, w_strb_r));
      end
      if (wr_here && wr_fld == FLD_CLR && w_strb_r[0]) begin
        clr_pend_nxt[p] = w_data_r[0];
      end
      if (hit && tot_r[p] != '1) begin
        tot_nxt[p] = tot_r[p] + 1'b1;
      end
      // Counts every received broadcast, dropped ones too
      if (tick) begin
        cnt_nxt[p] = hit ? CNT_W'(1) : '0;
      end else if (hit && cnt_r[p] != '1) begin
        cnt_nxt[p] = cnt_r[p] + 1'b1;
      end else begin
        cnt_nxt[p] = cnt_r[p];
      end
      if (tick) begin
        if (cnt_r[p] > peak_r[p]) begin
          peak_nxt[p] = cnt_r[p];
          elap_nxt[p] = '0;
        end else if (elap_r[p] != '1) begin
          elap_nxt[p] = elap_r[p] + 1'b1;
        end
      end
      if (save) begin
        lim_act_nxt[p] = lim_pend_r[p];
        // Clear is one-shot: a yes returns to no once applied
        clr_pend_nxt[p] = 1'b0;
        if (clr_pend_r[p]) begin
          peak_nxt[p] = '0;
          elap_nxt[p] = '0;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        lim_pend_r[p] <= LIMIT_RST;
        lim_act_r[p] <= LIMIT_RST;
        clr_pend_r[p] <= 1'b0;
        cnt_r[p] <= '0;
        peak_r[p] <= '0;
        tot_r[p] <= '0;
        elap_r[p] <= '0;
      end else begin
        lim_pend_r[p] <= lim_pend_nxt[p];
        lim_act_r[p] <= lim_act_nxt[p];
        clr_pend_r[p] <= clr_pend_nxt[p];
        cnt_r[p] <= cnt_nxt[p];
        peak_r[p] <= peak_nxt[p];
        tot_r[p] <= tot_nxt[p];
        elap_r[p] <= elap_nxt[p];
      end
    end
  end

  // ==========================================================
  // Global control and drop count
  always_comb begin
    nosup_nxt = nosup_r;
    drops_nxt = drops_r;
    if (wr_do && aw_addr_r == REG_CTRL && w_strb_r[0]) begin
      nosup_nxt = w_data_r[CTRL_NOSUP_BIT];
    end
    if (rx_fire && !pass && drops_r != '1) begin
      drops_nxt = drops_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nosup_r <= 1'b0;
      drops_r <= '0;
    end else begin
      nosup_r <= nosup_nxt;
      drops_r <= drops_nxt;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_comb begin
    aw_addr_nxt = aw_addr_r;
    aw_have_nxt = aw_have_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && !aw_have_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (wr_do) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // Writes to read-only fields are accepted and ignored
      bresp_nxt = (aw_addr_r == REG_CTRL || aw_addr_r == REG_DROPS ||
                   wr_port_ok) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_nxt[CTRL_NOSUP_BIT] = nosup_r;
      end else if (s_axi_araddr == REG_DROPS) begin
        rdata_nxt = drops_r;
      end else if (port_hit(s_axi_araddr)) begin
        case (ar_fld)
          FLD_LIMIT: rdata_nxt = 32'(lim_pend_r[ar_port]);
          FLD_CLR: rdata_nxt = 32'(clr_pend_r[ar_port]);
          FLD_TOTAL: rdata_nxt = tot_r[ar_port];
          FLD_PEAK: rdata_nxt = 32'(peak_r[ar_port]);
          FLD_ELAP: rdata_nxt = elap_r[ar_port];
          default: rdata_nxt = '0;
        endcase
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_r <= '0;
      aw_have_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      aw_addr_r <= aw_addr_nxt;
      aw_have_r <= aw_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule

// >>> verif/brl_checker.sv
// Purpose: port-level checks on the broadcast rate limiter
// Assumes: one clock, async active-low reset
// Notes: bound into every brl_top instance
`timescale 1ns/10ps
module brl_checker
  import brl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frames
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_bcast,
  input wire logic [PORT_W-1:0] rx_port,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic fwd_valid,
  input wire logic fwd_ready,
  input wire logic [PORT_W-1:0] fwd_port,
  input wire logic [DATA_W-1:0] fwd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // Register bus
  chk_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer withdrawn");
  chk_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_one_read: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  chk_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_err_data: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  // ==================================================
  // Frames
  chk_fwd_hold: assert property (
    fwd_valid && !fwd_ready
    |=> fwd_valid && $stable(fwd_port) && $stable(fwd_data))
    else $error("frame changed while stalled");
  chk_plain_pass: assert property (
    rx_valid && rx_ready && !rx_bcast && !fwd_valid
    |=> fwd_valid && fwd_port == $past(rx_port)
      && fwd_data == $past(rx_data))
    else $error("plain frame not forwarded");
endmodule

bind brl_top brl_checker u_chk (.sys_clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_ready,
  .rx_bcast, .rx_port, .rx_data, .fwd_valid, .fwd_ready, .fwd_port,
  .fwd_data);

// >>> verif/brl_fwd_model.sv
// Purpose: forwarding engine stand-in taking permitted frames
// Assumes: ready may be offered before valid
// Notes: full stall while stall is high, else random ready
`timescale 1ns/10ps
module brl_fwd_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic stall,
  // Forwarding handshake
  input wire logic fwd_valid,
  output logic fwd_ready
);
  int seed = 62;
  // Random back-pressure so the FIFO both fills and drains
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) fwd_ready <= 1'b0;
    else fwd_ready <= !stall && (!fwd_valid || $random(seed) % 2 == 0);
  end
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench of the broadcast rate limiter
// Assumes: short second of 400 cycles
// Notes: bursts start right after a tick seen by polling
`timescale 1ns/10ps
module testbench
  import brl_pkg::*;
;
  localparam int TICK = 400;
  logic sys_clk = 0, rst_n = 0, stall = 1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, rx_valid = 0, rx_bcast = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [PORT_W-1:0] rx_port = '0, fwd_port;
  logic [DATA_W-1:0] rx_data = '0, fwd_data;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_ready, fwd_valid, fwd_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic sup_off = 1'b0;
  logic [36:0] exp_q[$];
  int n_errors = 0, checked = 0, seed = 62;
  int cnt[NUM_PORTS], lim[NUM_PORTS];

  brl_top #(.TICK_LEN(TICK), .DEPTH(FIFO_DEPTH)) u_dut (.sys_clk, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_valid, .rx_ready, .rx_port, .rx_bcast, .rx_data,
    .fwd_valid, .fwd_ready, .fwd_port, .fwd_data);
  brl_fwd_model u_fwd (.sys_clk, .rst_n, .stall, .fwd_valid, .fwd_ready);

  initial forever #2.5 sys_clk = ~sys_clk;

  // ==================================================
  // Helpers
  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [ADDR_W-1:0] pa(input int p, logic [2:0] f);
    return PORT_BASE + ADDR_W'(p << PORT_SHIFT) + ADDR_W'({f, 2'b00});
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
      (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    chk({35'h0, s_axi_bresp}, {35'h0, er});
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    rd(a);
    chk({3'h0, rr, rv}, {3'h0, RESP_OKAY, e});
  endtask
  // Frame source; the expected result is noted when the frame is taken
  task automatic send(input int p, input logic b);
    logic [DATA_W-1:0] d;
    d = $random(seed);
    rx_valid <= 1'b1;
    rx_port <= PORT_W'(p);
    rx_bcast <= b;
    rx_data <= d;
    do @(posedge sys_clk); while (!rx_ready);
    if (!b || sup_off || cnt[p] < lim[p])
      exp_q.push_back({PORT_W'(p), d});
    if (b) cnt[p]++;
  endtask
  // Port 23 stays idle, so its elapsed count steps at every tick
  task automatic wait_tick();
    logic [31:0] e0;
    rd(pa(23, FLD_ELAP));
    e0 = rv;
    for (int i = 0; i < 200 && rv === e0; i++) rd(pa(23, FLD_ELAP));
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==================================================
  // Output monitor
  always @(posedge sys_clk) begin
    if (rst_n && fwd_valid && fwd_ready) begin
      if (exp_q.size() == 0) chk(37'h0, 37'h1);
      else chk({fwd_port, fwd_data}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end

  // ==================================================
  // Main sequence
  initial begin
    foreach (lim[i]) lim[i] = LIMIT_RST;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(pa(0, FLD_LIMIT), 32'(LIMIT_RST));
    rd_chk(pa(0, FLD_TOTAL), 32'h0);
    wr(pa(0, FLD_LIMIT), 32'd10, RESP_OKAY);
    wr(pa(5, FLD_LIMIT), 32'd20, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    lim[0] = 10;
    lim[5] = 20;
    rd_chk(pa(5, FLD_LIMIT), 32'd20);
    wait_tick();
    fork
      begin
        for (int i = 0; i < 26; i++) send(i % 2 ? 5 : 0, i < 24);
        rx_valid <= 1'b0;
      end
      begin
        repeat (30) @(posedge sys_clk);
        chk({36'h0, rx_ready}, 37'h0);
        stall <= 1'b0;
      end
    join
    for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge sys_clk);
    send(3, 1'b0);
    rx_valid <= 1'b0;
    wait_tick();
    rd_chk(pa(0, FLD_PEAK), 32'd12);
    rd_chk(pa(0, FLD_ELAP), 32'h0);
    rd_chk(pa(0, FLD_TOTAL), 32'd12);
    rd_chk(pa(5, FLD_PEAK), 32'd12);
    rd_chk(REG_DROPS, 32'h2);
    wr(pa(0, FLD_TOTAL), 32'h0, RESP_OKAY);
    rd_chk(pa(0, FLD_TOTAL), 32'd12);
    wait_tick();
    rd_chk(pa(0, FLD_ELAP), 32'h1);
    wr(pa(0, FLD_CLR), 32'h1, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd_chk(pa(0, FLD_PEAK), 32'h0);
    rd_chk(pa(0, FLD_ELAP), 32'h0);
    rd_chk(pa(5, FLD_PEAK), 32'd12);
    rd_chk(pa(0, FLD_CLR), 32'h0);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    rd_chk(REG_CTRL, 32'h2);
    // Twelve in one second would lose two with suppression on
    sup_off = 1'b1;
    for (int i = 0; i < 12; i++) send(0, 1'b1);
    rx_valid <= 1'b0;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge sys_clk);
    rd_chk(REG_DROPS, 32'h2);
    wr(12'h008, 32'h1, RESP_SLVERR);
    rd(12'h0fc);
    chk({3'h0, rr, rv}, {3'h0, RESP_SLVERR, 32'h0});
    chk({35'h0, exp_q.size() == 0, fwd_valid}, 37'h2);
    end_of_test();
  end
endmodule
